// File: core/watchdog_interval_timer.sv
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_map.svh"
module watchdog_interval_timer
    import wdt_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire wdt_pkg::addr_t addr_i,
    input wire wdt_pkg::data_t wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic debug_acknowledge_i,
    output wdt_pkg::data_t rdata_o,
    output logic sys_reset_o,
    output logic irq_o
);
    import wdt_pkg::*;

    // Limitations worth knowing before use:
    // The counter runs straight out of reset with the long default setting,
    // so software that wants a short interval must stop, load and restart.
    // A written count of zero parks the counter; no time-out follows.
    // Status bits record events only; the level interrupt also needs the
    // matching enable bit, so a masked event is still visible to polling.
    // Reserved control bits are stored as written and have no effect.

    logic [15:0] ctrl_ff; // watchdog_control
    logic [15:0] reload_ff; // watchdog_reload_value
    logic [15:0] count_ff; // watchdog_current_count
    logic [1:0] irq_status_ff; // Sticky events
    logic [1:0] irq_enable_ff; // Event mask
    logic [7:0] rst_cnt_ff; // Remaining reset cycles
    logic rst_active_ff; // Reset pulse running
    data_t rdata_ff; // Read data register

    // Address decode
    wire sel_ctrl = (addr_i == `WDT_CTRL_ADDR);
    wire sel_reload = (addr_i == `WDT_RELOAD_ADDR);
    wire sel_count = (addr_i == `WDT_COUNT_ADDR);
    wire sel_status = (addr_i == `WDT_IRQ_STATUS_ADDR);
    wire sel_enable = (addr_i == `WDT_IRQ_ENABLE_ADDR);
    wire sel_clear = (addr_i == `WDT_IRQ_CLEAR_ADDR);

    // Control fields
    wire run = ctrl_ff[`WDT_EN_BIT];
    wire int_en = ctrl_ff[`WDT_INT_EN_BIT];
    wire rst_en = ctrl_ff[`WDT_RST_EN_BIT];
    wire [7:0] presc = ctrl_ff[`WDT_PRESC_MSB:`WDT_PRESC_LSB];
    wire div_sel_e div_sel = div_sel_e'(ctrl_ff[`WDT_DIV_MSB:`WDT_DIV_LSB]);

    wire tick; // One counting step
    // Time-out: a tick seen while count already sits at zero would re-fire, so
    // the event is the tick taken at a count of one, which loads the reload value
    wire at_one = (count_ff == 16'h0001);
    wire timeout = tick && at_one;
    // Reset fires only when enabled and the core is not being debugged
    wire fire_rst = timeout && rst_en && !debug_acknowledge_i;
    wire ev_timeout = timeout && int_en;
    wire [1:0] events = {fire_rst, ev_timeout};
    wire [1:0] clr_mask = (wr_i && sel_clear) ? wdata_i[1:0] : 2'b00;

    wdt_tick_gen u_tick (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .run_i(run),
        .presc_i(presc),
        .div_i(div_sel),
        .tick_o(tick)
    );

    // Control register; reserved bits stored as written
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_ff <= `WDT_CTRL_RST;
        end else if (wr_i && sel_ctrl) begin
            ctrl_ff <= wdata_i[15:0];
        end
    end

    // Reload register
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reload_ff <= `WDT_RELOAD_RST;
        end else if (wr_i && sel_reload) begin
            reload_ff <= wdata_i[15:0];
        end
    end

    // Counter: software write wins over a tick in the same cycle
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            count_ff <= `WDT_COUNT_RST;
        end else if (wr_i && sel_count) begin
            count_ff <= wdata_i[15:0];
        end else if (timeout) begin
            count_ff <= reload_ff;
        end else if (tick && count_ff != 16'h0000) begin
            count_ff <= count_ff - 16'h0001;
        end
    end

    // Sticky status: a new event beats a clear in the same cycle
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_status_ff <= 2'b00;
        end else begin
            irq_status_ff <= (irq_status_ff & ~clr_mask) | events;
        end
    end

    // Interrupt enable
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_enable_ff <= 2'b00;
        end else if (wr_i && sel_enable) begin
            irq_enable_ff <= wdata_i[1:0];
        end
    end

    // Reset pulse timer; a new time-out during a pulse restarts it
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_cnt_ff <= 8'h00;
            rst_active_ff <= 1'b0;
        end else if (fire_rst) begin
            rst_cnt_ff <= `WDT_RST_PULSE_CYC - 8'h01;
            rst_active_ff <= 1'b1;
        end else if (rst_active_ff) begin
            rst_cnt_ff <= rst_cnt_ff - 8'h01;
            rst_active_ff <= (rst_cnt_ff != 8'h00);
        end
    end

    // Read mux
    wire [15:0] status_rd = {14'h0000, irq_status_ff};
    wire [15:0] enable_rd = {14'h0000, irq_enable_ff};
    wire [15:0] rd_mux = sel_ctrl ? ctrl_ff :
                         sel_reload ? reload_ff :
                         sel_count ? count_ff :
                         sel_status ? status_rd :
                         sel_enable ? enable_rd : 16'h0000;

    // Read data valid the cycle after the strobe only; unmapped reads zero
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_ff <= 32'h00000000;
        end else if (rd_i) begin
            rdata_ff <= {16'h0000, rd_mux};
        end else begin
            rdata_ff <= 32'h00000000;
        end
    end

    assign rdata_o = rdata_ff;
    assign sys_reset_o = rst_active_ff;
    assign irq_o = |(irq_status_ff & irq_enable_ff);

    // Reset pulse lasts exactly 128 cycles
    sequence rst_start_s;
        $rose(sys_reset_o);
    endsequence
    sequence rst_hold_s;
        sys_reset_o [*8];
    endsequence
    logic [7:0] hi_cnt_ff; // Helper: cycles reset has been high
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hi_cnt_ff <= 8'h00;
        end else begin
            hi_cnt_ff <= sys_reset_o ? hi_cnt_ff + 8'h01 : 8'h00;
        end
    end
    rst_len_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        $fell(sys_reset_o) && !$past(fire_rst) |-> $past(hi_cnt_ff) >= 8'h7F)
        else $error("reset pulse ended early");
    rst_max_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        sys_reset_o && rst_cnt_ff == 8'h00 && !fire_rst |=> !sys_reset_o)
        else $error("reset pulse too long");
    rst_seq_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        rst_start_s |-> rst_hold_s)
        else $error("reset pulse shorter than eight cycles");
    dbg_block_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        timeout && debug_acknowledge_i && !sys_reset_o |=> !sys_reset_o)
        else $error("reset raised during debug");
    rst_gate_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        timeout && rst_en && !debug_acknowledge_i |=> sys_reset_o && rst_cnt_ff == 8'h7F)
        else $error("enabled time-out gave no reset");
    reload_cnt_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        timeout && !(wr_i && sel_count) |=> count_ff == $past(reload_ff))
        else $error("counter not reloaded after time-out");
    dec_step_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        tick && !at_one && count_ff != 16'h0000 && !(wr_i && sel_count)
        |=> count_ff == $past(count_ff) - 16'h0001)
        else $error("counter did not decrement");
    irq_set_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        timeout && int_en |=> irq_status_ff[`WDT_ST_TIMEOUT_BIT])
        else $error("time-out status not set");
    stop_hold_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        !run && !(wr_i && sel_count) |=> $stable(count_ff))
        else $error("counter moved while stopped");
    rd_data_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        rd_i && sel_count |=> rdata_o == {16'h0000, $past(count_ff)})
        else $error("count read mismatch");

    // Checks below watch register paths that the tests reach only briefly

    // Read data stand one cycle, then drop back to zero
    rdata_idle_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        !rd_i |=> rdata_o == 32'h00000000)
        else $error("read data not idle");

    // Control write lands whole at the strobe edge
    ctrl_wr_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        wr_i && sel_ctrl |=> ctrl_ff == $past(wdata_i[15:0]))
        else $error("control write lost");

    // Reload write lands whole at the strobe edge
    reload_wr_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        wr_i && sel_reload |=> reload_ff == $past(wdata_i[15:0]))
        else $error("reload write lost");

    // Count write beats any tick in the same cycle
    cnt_wr_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        wr_i && sel_count |=> count_ff == $past(wdata_i[15:0]))
        else $error("count write lost");

    // Enable register keeps what was written
    en_wr_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        wr_i && sel_enable |=> irq_enable_ff == $past(wdata_i[1:0]))
        else $error("enable write lost");

    // No tick may leak out of a stopped divider chain
    tick_stop_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        !run |-> !tick)
        else $error("tick while stopped");

    // A parked zero count stays parked until software writes it
    zero_hold_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        count_ff == 16'h0000 && !(wr_i && sel_count) |=> count_ff == 16'h0000)
        else $error("zero count moved");

    // Every fired reset leaves its trace in the status
    rst_flag_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        fire_rst |=> irq_status_ff[`WDT_ST_RESET_BIT])
        else $error("reset status not set");

    // Pulse counter starts from one below the full length at each firing
    rst_load_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        fire_rst |=> rst_cnt_ff == `WDT_RST_PULSE_CYC - 8'h01)
        else $error("reset pulse counter not loaded");

    // With the gate off, an idle reset line stays idle
    gate_off_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        !rst_en && !rst_active_ff |=> !sys_reset_o)
        else $error("reset while gated off");

    // Reset line rises only after a firing time-out
    idle_low_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        !sys_reset_o && !fire_rst |=> !sys_reset_o)
        else $error("reset rose without time-out");

    // Interrupt bit off: a time-out must not set the time-out status bit
    no_int_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        timeout && !int_en && !irq_status_ff[`WDT_ST_TIMEOUT_BIT]
        |=> !irq_status_ff[`WDT_ST_TIMEOUT_BIT])
        else $error("status set with interrupt off");

    // Clear works when no new event competes with it
    clear_bit_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        wr_i && sel_clear && wdata_i[0] && !ev_timeout |=> !irq_status_ff[0])
        else $error("status not cleared");

    // An enabled, set time-out status bit must drive the interrupt line
    irq_line_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        irq_status_ff[0] && irq_enable_ff[0] |-> irq_o)
        else $error("interrupt line low");

    // Time-out under debug with no earlier reset event recorded
    sequence dbg_fire_s;
        timeout && debug_acknowledge_i && !irq_status_ff[`WDT_ST_RESET_BIT];
    endsequence
    dbg_flag_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        dbg_fire_s |=> !irq_status_ff[`WDT_ST_RESET_BIT])
        else $error("reset event recorded in debug");
endmodule : watchdog_interval_timer
`default_nettype wire

// File: core/wdt_map.svh
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH
// Register byte addresses, compared in full by the decoder
`define WDT_CTRL_ADDR 32'h01D30000
`define WDT_RELOAD_ADDR 32'h01D30004
`define WDT_COUNT_ADDR 32'h01D30008
`define WDT_IRQ_STATUS_ADDR 32'h01D3000C
`define WDT_IRQ_ENABLE_ADDR 32'h01D30010
`define WDT_IRQ_CLEAR_ADDR 32'h01D30014
// Control field positions
`define WDT_PRESC_MSB 15
`define WDT_PRESC_LSB 8
`define WDT_EN_BIT 5
`define WDT_DIV_MSB 4
`define WDT_DIV_LSB 3
`define WDT_INT_EN_BIT 2
`define WDT_RST_EN_BIT 0
// Reset values
`define WDT_CTRL_RST 16'h8021
`define WDT_RELOAD_RST 16'h8000
`define WDT_COUNT_RST 16'h8000
// Reset pulse length in master-clock cycles
`define WDT_RST_PULSE_CYC 8'h80
// Status bit positions
`define WDT_ST_TIMEOUT_BIT 0
`define WDT_ST_RESET_BIT 1
`endif

// File: core/wdt_pkg.sv
package wdt_pkg;
    // Second-stage division select codes
    typedef enum logic [1:0] {
        DIV_16 = 2'b00,
        DIV_32 = 2'b01,
        DIV_64 = 2'b10,
        DIV_128 = 2'b11
    } div_sel_e;
    // Bus address and data types
    typedef logic [31:0] addr_t;
    typedef logic [31:0] data_t;
endpackage : wdt_pkg

// File: core/wdt_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "wdt_map.svh"
// Two-stage tick divider: prescaler then power-of-two divider
module wdt_tick_gen
    import wdt_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic run_i,
    input wire logic [7:0] presc_i,
    input wire wdt_pkg::div_sel_e div_i,
    output logic tick_o
);
    import wdt_pkg::*;

    logic [7:0] presc_cnt_ff; // Prescaler phase
    logic [6:0] div_cnt_ff; // Second stage phase
    wire presc_wrap; // Prescaler period done
    wire [6:0] div_last; // Terminal count of second stage

    // Terminal count of the divider for a select code
    function automatic logic [6:0] div_term(input div_sel_e sel);
        unique case (sel)
            DIV_16: div_term = 7'h0F;
            DIV_32: div_term = 7'h1F;
            DIV_64: div_term = 7'h3F;
            DIV_128: div_term = 7'h7F;
        endcase
    endfunction : div_term

    assign presc_wrap = (presc_cnt_ff >= presc_i);
    assign div_last = div_term(div_i);
    // Comparison with >= so that a lowered setting never strands the count
    assign tick_o = run_i && presc_wrap && (div_cnt_ff >= div_last);

    // Prescaler: one wrap every presc+1 master clocks
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            presc_cnt_ff <= 8'h00;
        end else if (!run_i || presc_wrap) begin
            presc_cnt_ff <= 8'h00;
        end else begin
            presc_cnt_ff <= presc_cnt_ff + 8'h01;
        end
    end

    // Divider: advances once per prescaler wrap
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            div_cnt_ff <= 7'h00;
        end else if (!run_i || tick_o) begin
            div_cnt_ff <= 7'h00;
        end else if (presc_wrap) begin
            div_cnt_ff <= div_cnt_ff + 7'h01;
        end
    end
endmodule : wdt_tick_gen
`default_nettype wire

// File: testbench/watchdog_interval_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "wdt_map.svh"
// Case equality, so an unknown never passes for a match
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module watchdog_interval_timer_tb;
    import wdt_pkg::*;
    logic clk = 1'b0; // Master clock
    logic arst_n = 1'b0; // Block reset, active low
    addr_t addr = '0;
    data_t wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic dbg = 1'b0; // Core debug acknowledge
    data_t rdata;
    logic sys_reset;
    logic irq;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cyc = 0; // Free-running cycle count
    int rises = 0; // Rising edges of the reset output
    int last = 0;
    int gap = 0; // Cycles between the last two rises
    int width = 0; // Length of the running reset pulse
    logic prev = 1'b0;
    int r0;
    int k;
    // Fifth pass covers the prescaler ceiling
    int pv[5] = '{1, 1, 1, 1, 255};
    int rl[5] = '{9, 9, 9, 9, 1};
    always #5 clk = ~clk;
    watchdog_interval_timer dut (
        .sys_clk_i(clk),
        .arst_n_i(arst_n),
        .addr_i(addr),
        .wdata_i(wdata),
        .wr_i(wr),
        .rd_i(rd),
        .debug_acknowledge_i(dbg),
        .rdata_o(rdata),
        .sys_reset_o(sys_reset),
        .irq_o(irq)
    );
    // Spacing of reset rises and width of each pulse; a restart would show as a long pulse
    always @(posedge clk) begin
        cyc++;
        if (sys_reset === 1'b1 && !prev) begin
            rises++;
            gap = cyc - last;
            last = cyc;
        end
        if (sys_reset === 1'b1) width++;
        else if (width != 0) begin
            `CHK("reset pulse width", 128, width)
            width = 0;
        end
        prev = (sys_reset === 1'b1);
    end
    // Control word from its fields; reserved bits always zero
    function automatic logic [15:0] ctl(input logic [7:0] p, input logic en,
        input logic [1:0] dv, input logic ie, input logic re);
        return {p, 2'b00, en, dv, ie, 1'b0, re};
    endfunction : ctl
    // One-cycle write strobe
    task automatic wr_reg(input addr_t a, input logic [15:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= {16'h0000, v};
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    // One-cycle read strobe; data stand only in the following cycle
    task automatic chk_rd(input addr_t a, input data_t ex, input string nm);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        `CHK(nm, ex, rdata)
    endtask : chk_rd
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : test_done
    // Hang guard, well beyond the roughly 17.5k cycles of the run
    initial begin
        #400us;
        n_mismatch++;
        test_done();
    end
    initial begin
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        chk_rd(`WDT_CTRL_ADDR, 32'h00008021, "control reset");
        @(posedge clk);
        #1 `CHK("read data idle", 32'h00000000, rdata)
        chk_rd(`WDT_RELOAD_ADDR, 32'h00008000, "reload reset");
        chk_rd(`WDT_COUNT_ADDR, 32'h00008000, "count reset");
        chk_rd(32'h01D30020, 32'h00000000, "unmapped read");
        $display("test reset_values done");
        // Stopped counter holds a written count
        wr_reg(`WDT_CTRL_ADDR, ctl(8'h00, 1'b0, DIV_16, 1'b0, 1'b1));
        wr_reg(`WDT_COUNT_ADDR, 16'h0003);
        repeat (40) @(posedge clk);
        chk_rd(`WDT_COUNT_ADDR, 32'h00000003, "frozen count");
        wr_reg(`WDT_RELOAD_ADDR, 16'h0002);
        wr_reg(`WDT_IRQ_ENABLE_ADDR, 16'h0001);
        wr_reg(`WDT_CTRL_ADDR, ctl(8'h00, 1'b1, DIV_16, 1'b1, 1'b0));
        k = 0;
        while (irq !== 1'b1 && k < 60) begin
            @(posedge clk);
            k++;
        end
        `CHK("interval irq", 1'b1, irq)
        `CHK("no reset when gated", 0, rises)
        chk_rd(`WDT_COUNT_ADDR, 32'h00000002, "reloaded count");
        chk_rd(`WDT_IRQ_STATUS_ADDR, 32'h00000001, "status timeout");
        wr_reg(`WDT_IRQ_ENABLE_ADDR, 16'h0000);
        #1 `CHK("irq masked", 1'b0, irq)
        wr_reg(`WDT_IRQ_ENABLE_ADDR, 16'h0001);
        #1 `CHK("irq unmasked", 1'b1, irq)
        wr_reg(`WDT_IRQ_CLEAR_ADDR, 16'h0001);
        #1 `CHK("irq cleared", 1'b0, irq)
        wr_reg(`WDT_CTRL_ADDR, ctl(8'h00, 1'b1, DIV_16, 1'b0, 1'b0));
        repeat (80) @(posedge clk);
        `CHK("irq off when disabled", 1'b0, irq)
        $display("test interval done");
        // Period of time-outs for every divider code and the top prescaler value
        for (int i = 0; i < 5; i++) begin
            wr_reg(`WDT_CTRL_ADDR, ctl(8'(pv[i]), 1'b0, 2'(i % 4), 1'b0, 1'b1));
            wr_reg(`WDT_COUNT_ADDR, 16'(rl[i]));
            wr_reg(`WDT_RELOAD_ADDR, 16'(rl[i]));
            r0 = rises;
            wr_reg(`WDT_CTRL_ADDR, ctl(8'(pv[i]), 1'b1, 2'(i % 4), 1'b0, 1'b1));
            k = 0;
            while (rises < r0 + 2 && k < 10000) begin
                @(posedge clk);
                k++;
            end
            `CHK("time-out period", rl[i] * (pv[i] + 1) * (16 << (i % 4)), gap)
        end
        wr_reg(`WDT_CTRL_ADDR, ctl(8'h00, 1'b0, DIV_16, 1'b0, 1'b1));
        repeat (140) @(posedge clk);
        $display("test dividers done");
        // Debug acknowledge holds off the reset but not the interrupt
        dbg <= 1'b1;
        wr_reg(`WDT_IRQ_CLEAR_ADDR, 16'h0003);
        wr_reg(`WDT_COUNT_ADDR, 16'h0002);
        wr_reg(`WDT_RELOAD_ADDR, 16'h0002);
        r0 = rises;
        wr_reg(`WDT_CTRL_ADDR, ctl(8'h00, 1'b1, DIV_16, 1'b1, 1'b1));
        repeat (100) @(posedge clk);
        `CHK("no reset in debug", r0, rises)
        `CHK("irq in debug", 1'b1, irq)
        chk_rd(`WDT_IRQ_STATUS_ADDR, 32'h00000001, "status in debug");
        @(posedge clk);
        dbg <= 1'b0;
        k = 0;
        while (rises == r0 && k < 40) begin
            @(posedge clk);
            k++;
        end
        wr_reg(`WDT_CTRL_ADDR, ctl(8'h00, 1'b0, DIV_16, 1'b0, 1'b0));
        `CHK("reset after debug", r0 + 1, rises)
        chk_rd(`WDT_IRQ_STATUS_ADDR, 32'h00000003, "status reset fired");
        repeat (140) @(posedge clk);
        $display("test debug done");
        // Second reset in mid-run clears the interrupt and restores the control reset value
        @(posedge clk);
        arst_n <= 1'b0;
        #1 `CHK("irq in reset", 1'b0, irq)
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        chk_rd(`WDT_CTRL_ADDR, 32'h00008021, "control after reset");
        $display("test mid_reset done");
        test_done();
    end
endmodule : watchdog_interval_timer_tb
`default_nettype wire
